// ===== rtl/pcrc_map.vh
// Behaviour
// - Ratio field bits 3:0 select multiplication
// - Reset ratio zero, bypass gives input/2
// - Codes 1..10 give input*n/2; others reserved
// - Strap low at reset: input drives core
// - Only device reset clears ratio register
// - Group registers need protected access mode
// - Input lost with ratio nonzero: limp clock; the code also requires the PLL not to be strap-disabled
// - Watchdog counter holds during limp mode
// - Settling takes 131072 input clock cycles
// - Fast prescaler register at word 0x701A
// - Slow prescaler register at word 0x701B
// - Clock gate register at word 0x701C
// - System clock out tracks core clock
`ifndef PCRC_MAP_VH
`define PCRC_MAP_VH

// Word indices; byte address is four times the index
`define PCRC_IDX_FAST_PRESCALE 16'h701A
`define PCRC_IDX_SLOW_PRESCALE 16'h701B
`define PCRC_IDX_CLOCK_GATE 16'h701C
`define PCRC_IDX_PLL_RATIO 16'h7021
`define PCRC_IDX_CLOCK_STATUS 16'h7024

`define PCRC_RATIO_W 4
`define PCRC_RATIO_RESET 4'h0
`define PCRC_RATIO_BYPASS 4'h0
`define PCRC_RATIO_MAX 4'hA
`define PCRC_PRESCALE_RESET 16'h0000
`define PCRC_GATE_RESET 16'h0000

// Status bit positions
`define PCRC_ST_SETTLED 0
`define PCRC_ST_LIMP 1
`define PCRC_ST_DISABLED 2
`define PCRC_ST_RESERVED_CODE 3

// Settle time in input clock cycles
`define PCRC_SETTLE_INPUT_CYCLES 131072
// Edge count after reset release at which the strap synchroniser holds the pin
`define PCRC_STRAP_CAPTURE 2'b10
// System clocks without an input edge before loss is declared
`define PCRC_LOSS_SYS_CYCLES 64

`endif

// ===== rtl/pcrc_sync.v
`timescale 1ns/1ps
module pcrc_sync (
	// Clock and reset
	input wire i_sys_clk,
	input wire i_rst,
	// Asynchronous level in, synchronised level out
	input wire i_async,
	output reg o_sync
);
	reg stage1;

	always @(posedge i_sys_clk or posedge i_rst) begin
		if (i_rst) begin
			stage1 <= 1'b0;
			o_sync <= 1'b0;
		end else begin
			stage1 <= i_async;
			o_sync <= stage1;
		end
	end
endmodule

// ===== rtl/pcrc_timer.v
`timescale 1ns/1ps
module pcrc_timer #(
	parameter WIDTH = 18,
	parameter [WIDTH-1:0] COUNT = {WIDTH{1'b1}}
) (
	// Clock and reset
	input wire i_sys_clk,
	input wire i_rst,
	// Restart, count step and expiry
	input wire i_load,
	input wire i_step,
	output reg o_done
);
	reg [WIDTH-1:0] remaining;

	// Load wins over step; done stays high until next load
	always @(posedge i_sys_clk or posedge i_rst) begin
		if (i_rst) begin
			remaining <= {WIDTH{1'b0}};
			o_done <= 1'b1;
		end else if (i_load) begin
			remaining <= COUNT;
			o_done <= 1'b0;
		end else if (i_step && !o_done) begin
			remaining <= remaining - {{(WIDTH-1){1'b0}}, 1'b1};
			if (remaining == {{(WIDTH-1){1'b0}}, 1'b1})
				o_done <= 1'b1;
		end
	end
endmodule

// ===== rtl/pcrc_top.v
// Register access over APB was decided locally.
`timescale 1ns/1ps
`include "pcrc_map.vh"
module pcrc_top #(
	parameter ADDR_W = 18,
	parameter SETTLE_CYCLES = `PCRC_SETTLE_INPUT_CYCLES,
	parameter LOSS_CYCLES = `PCRC_LOSS_SYS_CYCLES
) (
	// Clock and resets
	input wire i_sys_clk,
	input wire i_rst,
	input wire i_debug_rst,
	// APB slave
	input wire i_psel,
	input wire i_penable,
	input wire i_pwrite,
	input wire [ADDR_W-1:0] i_paddr,
	input wire [31:0] i_pwdata,
	output reg [31:0] o_prdata,
	output reg o_pready,
	output reg o_pslverr,
	// Protected access mode from the core
	input wire i_protected_access_enable,
	// Pins and analogue PLL output
	input wire i_input_clock,
	input wire i_pll_vco,
	input wire i_pll_disable_strap_n,
	// Clock control outputs
	output reg o_system_clock_out,
	output reg [3:0] o_pll_mult,
	output reg o_pll_bypass,
	output reg o_pll_disabled,
	output reg o_pll_settled,
	output reg o_limp_mode,
	output reg o_watchdog_hold,
	output reg [15:0] o_fast_prescale,
	output reg [15:0] o_slow_prescale,
	output reg [15:0] o_periph_clock_gate
);
	localparam [ADDR_W-1:0] A_FAST = {`PCRC_IDX_FAST_PRESCALE, 2'b00};
	localparam [ADDR_W-1:0] A_SLOW = {`PCRC_IDX_SLOW_PRESCALE, 2'b00};
	localparam [ADDR_W-1:0] A_GATE = {`PCRC_IDX_CLOCK_GATE, 2'b00};
	localparam [ADDR_W-1:0] A_RATIO = {`PCRC_IDX_PLL_RATIO, 2'b00};
	localparam [ADDR_W-1:0] A_STATUS = {`PCRC_IDX_CLOCK_STATUS, 2'b00};

	wire in_s;
	wire vco_s;
	wire strap_s;
	reg in_d;
	reg vco_d;
	reg [1:0] strap_wait;
	reg src_vco;
	wire want_vco;
	wire hold_low;
	wire commit;
	reg [3:0] ratio;
	wire settle_done;
	wire loss_done;
	wire in_rise;
	wire vco_rise;
	wire access;
	wire ratio_write;
	reg addr_hit;
	reg [31:0] next_rdata;

	pcrc_sync u_sync_in (
		.i_sys_clk(i_sys_clk),
		.i_rst(i_rst),
		.i_async(i_input_clock),
		.o_sync(in_s)
	);

	pcrc_sync u_sync_vco (
		.i_sys_clk(i_sys_clk),
		.i_rst(i_rst),
		.i_async(i_pll_vco),
		.o_sync(vco_s)
	);

	pcrc_sync u_sync_strap (
		.i_sys_clk(i_sys_clk),
		.i_rst(i_rst),
		.i_async(i_pll_disable_strap_n),
		.o_sync(strap_s)
	);

	always @(posedge i_sys_clk or posedge i_rst) begin
		if (i_rst) begin
			in_d <= 1'b0;
			vco_d <= 1'b0;
		end else begin
			in_d <= in_s;
			vco_d <= vco_s;
		end
	end

	assign in_rise = in_s & ~in_d;
	assign vco_rise = vco_s & ~vco_d;

	// Strap sampled once the synchroniser holds the pin, not its reset value
	always @(posedge i_sys_clk or posedge i_rst) begin
		if (i_rst) begin
			strap_wait <= 2'b00;
			o_pll_disabled <= 1'b0;
		end else if (strap_wait <= `PCRC_STRAP_CAPTURE) begin
			strap_wait <= strap_wait + 2'b01;
			if (strap_wait == `PCRC_STRAP_CAPTURE)
				o_pll_disabled <= ~strap_s;
		end
	end

	// APB access phase, refused outside protected mode
	assign access = i_psel & i_penable & ~o_pready;
	// Writes land at the edge where the master samples ready high
	assign commit = i_psel & i_penable & o_pready;
	assign ratio_write = commit & i_pwrite & i_protected_access_enable & addr_hit
		& (i_paddr == A_RATIO);

	always @* begin
		addr_hit = 1'b1;
		next_rdata = 32'h0000_0000;
		case (i_paddr)
			A_FAST: next_rdata = {16'h0000, o_fast_prescale};
			A_SLOW: next_rdata = {16'h0000, o_slow_prescale};
			A_GATE: next_rdata = {16'h0000, o_periph_clock_gate};
			A_RATIO: next_rdata = {28'h000_0000, ratio};
			A_STATUS: begin
				next_rdata[`PCRC_ST_SETTLED] = o_pll_settled;
				next_rdata[`PCRC_ST_LIMP] = o_limp_mode;
				next_rdata[`PCRC_ST_DISABLED] = o_pll_disabled;
				next_rdata[`PCRC_ST_RESERVED_CODE] = (ratio > `PCRC_RATIO_MAX);
			end
			default: addr_hit = 1'b0;
		endcase
	end

	always @(posedge i_sys_clk or posedge i_rst) begin
		if (i_rst) begin
			o_pready <= 1'b0;
			o_pslverr <= 1'b0;
			o_prdata <= 32'h0000_0000;
		end else begin
			o_pready <= access;
			o_pslverr <= access & ~(addr_hit & i_protected_access_enable);
			o_prdata <= (access && !i_pwrite && addr_hit && i_protected_access_enable)
				? next_rdata : 32'h0000_0000;
		end
	end

	// Ratio cleared by device reset alone
	always @(posedge i_sys_clk or posedge i_rst) begin
		if (i_rst) begin
			ratio <= `PCRC_RATIO_RESET;
		end else if (ratio_write) begin
			ratio <= i_pwdata[`PCRC_RATIO_W-1:0];
		end
	end

	// Prescalers and gates also follow debugger reset
	always @(posedge i_sys_clk or posedge i_rst) begin
		if (i_rst) begin
			o_fast_prescale <= `PCRC_PRESCALE_RESET;
			o_slow_prescale <= `PCRC_PRESCALE_RESET;
			o_periph_clock_gate <= `PCRC_GATE_RESET;
		end else if (i_debug_rst) begin
			o_fast_prescale <= `PCRC_PRESCALE_RESET;
			o_slow_prescale <= `PCRC_PRESCALE_RESET;
			o_periph_clock_gate <= `PCRC_GATE_RESET;
		end else if (commit && i_pwrite && i_protected_access_enable) begin
			if (i_paddr == A_FAST)
				o_fast_prescale <= i_pwdata[15:0];
			if (i_paddr == A_SLOW)
				o_slow_prescale <= i_pwdata[15:0];
			if (i_paddr == A_GATE)
				o_periph_clock_gate <= i_pwdata[15:0];
		end
	end

	// Settle count in input clock edges after each ratio write
	pcrc_timer #(
		.WIDTH(18),
		.COUNT(SETTLE_CYCLES[17:0])
	) u_settle (
		.i_sys_clk(i_sys_clk),
		.i_rst(i_rst),
		.i_load(ratio_write),
		.i_step(in_rise),
		.o_done(settle_done)
	);

	// Loss watch: reloaded on each input edge
	pcrc_timer #(
		.WIDTH(16),
		.COUNT(LOSS_CYCLES[15:0])
	) u_loss (
		.i_sys_clk(i_sys_clk),
		.i_rst(i_rst),
		.i_load(in_rise),
		.i_step(1'b1),
		.o_done(loss_done)
	);

	always @(posedge i_sys_clk or posedge i_rst) begin
		if (i_rst) begin
			o_pll_mult <= `PCRC_RATIO_RESET;
			o_pll_bypass <= 1'b1;
			o_pll_settled <= 1'b1;
			o_limp_mode <= 1'b0;
			o_watchdog_hold <= 1'b0;
		end else begin
			o_pll_mult <= ratio;
			o_pll_bypass <= (ratio == `PCRC_RATIO_BYPASS) & ~o_pll_disabled;
			o_pll_settled <= settle_done & ~ratio_write;
			o_limp_mode <= loss_done & ~o_pll_disabled
				& (ratio != `PCRC_RATIO_BYPASS);
			o_watchdog_hold <= loss_done & ~o_pll_disabled
				& (ratio != `PCRC_RATIO_BYPASS);
		end
	end

	// Source hand-over only while the output is low keeps every high phase whole
	assign want_vco = (ratio != `PCRC_RATIO_BYPASS);
	assign hold_low = (src_vco != want_vco) & ~o_system_clock_out;

	always @(posedge i_sys_clk or posedge i_rst) begin
		if (i_rst) begin
			src_vco <= 1'b0;
		end else if (!o_system_clock_out) begin
			src_vco <= want_vco;
		end
	end

	// Single toggle flop; a source change keeps whole high phases, the low phase may be cut short or stretched
	always @(posedge i_sys_clk or posedge i_rst) begin
		if (i_rst) begin
			o_system_clock_out <= 1'b0;
		end else if (o_pll_disabled) begin
			o_system_clock_out <= in_s;
		end else if (hold_low) begin
			o_system_clock_out <= 1'b0;
		end else if (!src_vco) begin
			if (in_rise)
				o_system_clock_out <= ~o_system_clock_out;
		end else if (vco_rise) begin
			o_system_clock_out <= ~o_system_clock_out;
		end
	end
endmodule

// ===== test/pcrc_top_sva.sv
`timescale 1ns/1ps
module pcrc_top_sva (
	// Clock and resets
	input logic i_sys_clk,
	input logic i_rst,
	input logic i_debug_rst,
	// Register bus
	input logic i_psel,
	input logic i_penable,
	input logic i_protected_access_enable,
	input logic [31:0] o_prdata,
	input logic o_pready,
	input logic o_pslverr,
	// Clock control
	input logic [3:0] o_pll_mult,
	input logic o_pll_bypass,
	input logic o_pll_disabled,
	input logic o_limp_mode,
	input logic o_watchdog_hold
);
	default clocking @(posedge i_sys_clk);
	endclocking
	default disable iff (i_rst);
	sequence s_acc;
		i_psel && i_penable && !o_pready;
	endsequence
	a_ready_pulse: assert property (s_acc |=> o_pready ##1 !o_pready)
		else $error("ready is not a one-cycle answer");
	a_prot_refuse: assert property (s_acc ##0 !i_protected_access_enable |=> o_pslverr)
		else $error("unprotected access not refused");
	a_err_data: assert property (o_pslverr |-> o_prdata == 32'h0)
		else $error("refused access returns data");
	a_bypass_zero: assert property (o_pll_mult != 4'h0 |-> !o_pll_bypass)
		else $error("bypass with nonzero ratio");
	a_strap_nobyp: assert property (o_pll_disabled |=> !o_pll_bypass)
		else $error("bypass while pll disabled");
	a_limp_cause: assert property (o_limp_mode |-> o_pll_mult != 4'h0 && !o_pll_disabled)
		else $error("limp mode without enabled pll");
	a_limp_hold: assert property (o_watchdog_hold == o_limp_mode)
		else $error("watchdog hold differs from limp");
	a_debug_keep: assert property (i_debug_rst |=> $stable(o_pll_mult))
		else $error("debug reset changed ratio");
endmodule
bind pcrc_top pcrc_top_sva i_sva (
	.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_debug_rst(i_debug_rst), .i_psel(i_psel),
	.i_penable(i_penable), .i_protected_access_enable(i_protected_access_enable),
	.o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
	.o_pll_mult(o_pll_mult), .o_pll_bypass(o_pll_bypass), .o_pll_disabled(o_pll_disabled),
	.o_limp_mode(o_limp_mode), .o_watchdog_hold(o_watchdog_hold)
);

// ===== test/pcrc_osc.sv
`timescale 1ns/1ps
module pcrc_osc #(parameter int HALF_NS = 2000) (
	// Bench control
	input logic i_run,
	input logic [3:0] i_mult,
	// Clock pin and vco
	output logic o_input_clock,
	output logic o_pll_vco
);
	int d;
	initial begin
		o_input_clock = 1'h0;
		forever #(HALF_NS) if (i_run) o_input_clock = ~o_input_clock;
	end
	// Vco keeps running when the input stops
	initial begin
		o_pll_vco = 1'h0;
		forever begin
			d = i_mult;
			#(HALF_NS / (d > 0 ? d : 1)) o_pll_vco = ~o_pll_vco;
		end
	end
endmodule

// ===== test/pll_clock_ratio_control_tb.sv
`timescale 1ns/1ps
`include "pcrc_map.vh"
module pll_clock_ratio_control_tb;
	logic i_sys_clk = 1'h0, i_rst = 1'h1, i_debug_rst = 1'h0, i_psel = 1'h0, i_penable = 1'h0;
	logic i_pwrite = 1'h0, i_protected_access_enable = 1'h1, i_pll_disable_strap_n = 1'h1;
	logic [17:0] i_paddr = 18'h0;
	logic [31:0] i_pwdata = 32'h0, o_prdata;
	logic i_input_clock, i_pll_vco, o_pready, o_pslverr, o_system_clock_out, o_pll_bypass;
	logic o_pll_disabled, o_pll_settled, o_limp_mode, o_watchdog_hold, run = 1'h1;
	logic [3:0] o_pll_mult;
	logic [15:0] o_fast_prescale, o_slow_prescale, o_periph_clock_gate;
	logic [32:0] rd;
	int error_cnt = 0, compares = 0;
	always #50 i_sys_clk = ~i_sys_clk;
	// Loss limit must exceed the 40-cycle input period plus sync delay
	pcrc_top #(.SETTLE_CYCLES(8), .LOSS_CYCLES(64)) i_dut (
		.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_debug_rst(i_debug_rst), .i_psel(i_psel),
		.i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
		.o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
		.i_protected_access_enable(i_protected_access_enable),
		.i_input_clock(i_input_clock), .i_pll_vco(i_pll_vco),
		.i_pll_disable_strap_n(i_pll_disable_strap_n),
		.o_system_clock_out(o_system_clock_out), .o_pll_mult(o_pll_mult),
		.o_pll_bypass(o_pll_bypass), .o_pll_disabled(o_pll_disabled),
		.o_pll_settled(o_pll_settled), .o_limp_mode(o_limp_mode),
		.o_watchdog_hold(o_watchdog_hold), .o_fast_prescale(o_fast_prescale),
		.o_slow_prescale(o_slow_prescale), .o_periph_clock_gate(o_periph_clock_gate)
	);
	pcrc_osc i_osc (.i_run(run), .i_mult(o_pll_mult), .o_input_clock(i_input_clock),
		.o_pll_vco(i_pll_vco));
	task automatic chk(string nm, logic [32:0] got, logic [32:0] exp);
		compares++;
		if (got !== exp) begin
			error_cnt++;
			$display("CHECK FAILED %s exp %h got %h", nm, exp, got);
		end
	endtask
	task automatic end_sim;
		$display("errors %0d compares %0d", error_cnt, compares);
		if (error_cnt == 0 && compares > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic tick(int n);
		repeat (n) @(posedge i_sys_clk);
	endtask
	task automatic till(string nm, ref logic s, input logic v, int n);
		while (s !== v && n-- > 0)
			tick(1);
		chk(nm, s, v);
		if (s !== v)
			end_sim;
	endtask
	task automatic apb(logic w, logic [15:0] ix, logic [31:0] wd);
		int n = 0;
		tick(1);
		i_psel <= 1'h1;
		i_pwrite <= w;
		i_paddr <= {ix, 2'h0};
		i_pwdata <= wd;
		tick(1);
		i_penable <= 1'h1;
		do begin
			tick(1);
			n++;
		end while (o_pready !== 1'h1 && n < 20);
		rd = {o_pslverr, o_prdata};
		i_psel <= 1'h0;
		i_penable <= 1'h0;
		if (o_pready !== 1'h1)
			till("ready", o_pready, 1'h1, 0);
	endtask
	task automatic rdc(string nm, logic [15:0] ix, logic [32:0] exp);
		apb(1'h0, ix, 32'h0);
		chk(nm, rd, exp);
	endtask
	// Rises of the clock output in 800 cycles, one of slack for phase
	task automatic rate(int exp);
		int r = 0;
		logic p = o_system_clock_out;
		repeat (800) begin
			tick(1);
			r += int'(o_system_clock_out & !p);
			p = o_system_clock_out;
		end
		chk("rate", r >= exp - 1 && r <= exp + 1, 1'h1);
	endtask
	task automatic t_reset;
		chk("bypass", o_pll_bypass, 1'h1);
		rdc("ratio", `PCRC_IDX_PLL_RATIO, 33'h0);
		rate(10);
	endtask
	task automatic t_regs;
		logic [15:0] ix[3] = '{`PCRC_IDX_FAST_PRESCALE, `PCRC_IDX_SLOW_PRESCALE,
			`PCRC_IDX_CLOCK_GATE};
		for (int k = 0; k < 3; k++) begin
			apb(1'h1, ix[k], 32'hFFFF_0000 | (32'h3 << k));
			rdc("reg", ix[k], 33'h3 << k);
		end
		chk("pins", {o_fast_prescale, o_slow_prescale[3:0], o_periph_clock_gate[3:0]},
			33'h36C);
	endtask
	task automatic t_prot;
		i_protected_access_enable <= 1'h0;
		apb(1'h1, `PCRC_IDX_FAST_PRESCALE, 32'hF0);
		chk("prot wr", rd, 33'h1_0000_0000);
		rdc("prot rd", `PCRC_IDX_FAST_PRESCALE, 33'h1_0000_0000);
		i_protected_access_enable <= 1'h1;
		rdc("kept", `PCRC_IDX_FAST_PRESCALE, 33'h3);
		rdc("hole", 16'h701D, 33'h1_0000_0000);
	endtask
	task automatic t_ratio;
		for (int c = 0; c < 12; c++) begin
			apb(1'h1, `PCRC_IDX_PLL_RATIO, 32'hFFFF_FFF0 | c);
			rdc("ratio", `PCRC_IDX_PLL_RATIO, 33'(c));
		end
		rdc("status", `PCRC_IDX_CLOCK_STATUS, 33'h8);
		// No watchdog runs in this bench while the ratio changes
		apb(1'h1, `PCRC_IDX_PLL_RATIO, 32'hA);
		tick(250);
		chk("early", o_pll_settled, 1'h0);
		till("settled", o_pll_settled, 1'h1, 200);
		rate(100);
	endtask
	task automatic t_debug;
		i_debug_rst <= 1'h1;
		tick(1);
		i_debug_rst <= 1'h0;
		tick(2);
		chk("mult", o_pll_mult, 33'hA);
		chk("prescale", o_fast_prescale, 33'h0);
	endtask
	task automatic t_limp;
		run <= 1'h0;
		till("limp", o_limp_mode, 1'h1, 100);
		chk("wd hold", o_watchdog_hold, 1'h1);
		rate(100);
		run <= 1'h1;
		till("back", o_limp_mode, 1'h0, 100);
	endtask
	task automatic t_strap;
		i_rst <= 1'h1;
		i_pll_disable_strap_n <= 1'h0;
		tick(3);
		i_rst <= 1'h0;
		// Strap lands on the third edge, bypass follows one edge later
		tick(5);
		chk("disabled", {o_pll_disabled, o_pll_bypass}, 33'h2);
		rdc("ratio", `PCRC_IDX_PLL_RATIO, 33'h0);
		rate(20);
	endtask
	initial begin
		tick(20);
		i_rst <= 1'h0;
		tick(2);
		t_reset;
		t_regs;
		t_prot;
		t_ratio;
		t_debug;
		t_limp;
		t_strap;
		end_sim;
	end
endmodule
